// >>> shared/i2cra_pkg.sv
// package for the two-wire register access target and its master
// assumes both ends share this one set of constants
package i2cra_pkg;
  localparam logic [2:0] ADDR_FIXED_HI = 3'h3; // upper target address bits 011
  localparam logic [3:0] ADDR_USER_RST = 4'h6; // user address bits after reset
  localparam logic [7:0] LOC_ADDR_CFG = 8'h7d; // address configuration location
  localparam int ADDR_CFG_MSB = 7; // user bits sit at [7:4]
  localparam int ADDR_CFG_LSB = 4;
  localparam logic [7:0] LOC_WRITE_LAST = 8'h4f; // last writable by auto-increment
  localparam logic [7:0] LOC_RO_LIMIT = 8'h20; // first location the bus may write
  localparam logic [7:0] LOC_FUNC_CMD = 8'hfe; // function_command_byte location
  localparam logic [7:0] READ_PAST_END = 8'hff; // value past the top of memory
  localparam logic [7:0] MEM_RST = 8'h00; // shadow memory reset value
  localparam int MEM_DEPTH = 256;
  localparam int BITS_PER_BYTE = 8;
  localparam int CLK_MHZ = 100; // local clock rate
  localparam int SCL_HALF_NS = 1250; // half period of a 400 kHz link clock
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ) / 1000;
  // read-only or reserved locations inside the writable window
  function automatic logic loc_read_only(input logic [7:0] loc);
    return (loc < LOC_RO_LIMIT); // lower block holds measured values
  endfunction
endpackage

// >>> shared/i2cra_if.sv
// two-wire bus carrier joining target and master ends
// assumes open-drain wired-and with pull-up; enables are low while driving
`timescale 1ns/10ps
`default_nettype none
interface i2cra_if;
  logic scl_m_out;
  logic scl_m_oe_n;
  logic sda_m_out;
  logic sda_m_oe_n;
  logic sda_t_out;
  logic sda_t_oe_n;
  logic scl;
  logic sda;
  // pull-up wins unless some end drives low
  assign scl = (scl_m_oe_n | scl_m_out);
  assign sda = (sda_m_oe_n | sda_m_out) & (sda_t_oe_n | sda_t_out);
  modport target (input scl, input sda, output sda_t_out, output sda_t_oe_n);
  modport master (input scl, input sda, output scl_m_out, output scl_m_oe_n,
    output sda_m_out, output sda_m_oe_n);
endinterface
`default_nettype wire

// >>> hw/i2cra_sync.sv
// bus condition detector: two-stage synchronisers for scl and sda
// assumes lines come from another clock domain
`timescale 1ns/10ps
`default_nettype none
module i2cra_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
  } i2cra_sync_st_t;
  i2cra_sync_st_t st_r, st_nxt;
  // first stage only feeds second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_s = {st_r.scl_s[0], scl_in};
    st_nxt.sda_s = {st_r.sda_s[0], sda_in};
    st_nxt.scl_d = st_r.scl_s[1];
    st_nxt.sda_d = st_r.sda_s[1];
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '1; // idle bus reads high
    end else begin
      st_r <= st_nxt;
    end
  end
  assign scl_out = st_r.scl_s[1];
  assign sda_out = st_r.sda_s[1];
  assign scl_rise_out = st_r.scl_s[1] & ~st_r.scl_d;
  assign scl_fall_out = ~st_r.scl_s[1] & st_r.scl_d;
  // sda moving while scl high is a bus condition
  assign start_out = st_r.scl_s[1] & st_r.scl_d & st_r.sda_d & ~st_r.sda_s[1];
  assign stop_out = st_r.scl_s[1] & st_r.scl_d & ~st_r.sda_d & st_r.sda_s[1];
endmodule // i2cra_sync
`default_nettype wire

// >>> hw/i2cra_target.sv
// two-wire register access target: address match, pointer, shadow memory
// assumes master makes scl; this end only watches it and drives sda low
// Behaviour
// - probe: start, address, direction, ack slot
// - every byte followed by acknowledge
// - write: address, pointer, data at pointer
// - write: target drives sda only in ack
// - byte n stored at pointer plus n
// - master ends write with stop/restart
// - pointer advances right after each lsb
// - auto-increment write past 4fh discarded
// - read-only or reserved writes discarded
// - auto-incremented write to command location discarded
// - no store for cut or unacknowledged bytes
// - writes update shadow copy only
// - read: pointer write, restart, direction one
// - target drives sda from address ack
// - read msb first from pointer, advancing
// - reads past ffh return ffh
// - reserved reads return anything
// - master nack: release sda, stop sending
// - master ends read with nack, stop
// - address 011 plus four user bits
// - ack only on matching address
// - multi-byte values msb at even address
`timescale 1ns/10ps
`default_nettype none
module i2cra_target (
  input wire logic clk_in,
  input wire logic arst_n_in,
  i2cra_if.target bus,
  output logic [7:0] wr_loc_out,
  output logic [7:0] wr_data_out,
  output logic wr_stb_out,
  output logic busy_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_ACK, ST_MACK
  } i2cra_tstate_t;
  typedef struct packed {
    i2cra_tstate_t state;
    i2cra_tstate_t after_ack; // phase that follows the ack slot
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [7:0] ptr;
    logic wrapped; // pointer passed ffh during a read or write burst
    logic autoinc; // pointer reached by increment, not set
    logic pend; // a received byte waits for its ack
    logic [7:0] pend_loc;
    logic [7:0] pend_data;
    logic sda_oe_n;
    logic sda_o;
    logic [7:0] wr_loc;
    logic [7:0] wr_data;
    logic wr_stb;
    logic busy;
  } i2cra_tst_t;
  i2cra_tst_t st_r, st_nxt;
  logic [7:0] mem_r [i2cra_pkg::MEM_DEPTH]; // shadow copy only
  logic [3:0] user_addr;
  logic sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rd_byte;
  logic [6:0] my_addr;
  i2cra_sync u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl_out(),
    .sda_out(sda_s),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(bus_start),
    .stop_out(bus_stop)
  );
  assign user_addr =
    mem_r[i2cra_pkg::LOC_ADDR_CFG][i2cra_pkg::ADDR_CFG_MSB:i2cra_pkg::ADDR_CFG_LSB];
  assign my_addr = {i2cra_pkg::ADDR_FIXED_HI, user_addr};
  // past the top the pointer wraps; flag turns the data to ffh
  assign rd_byte = st_r.wrapped ? i2cra_pkg::READ_PAST_END : mem_r[st_r.ptr];
  // write filter: range, read-only, command by increment
  function automatic logic wr_allowed(input logic [7:0] loc, input logic inc);
    logic ok;
    ok = 1'b1;
    if (inc && loc > i2cra_pkg::LOC_WRITE_LAST) ok = 1'b0;
    if (i2cra_pkg::loc_read_only(loc)) ok = 1'b0;
    if (inc && loc == i2cra_pkg::LOC_FUNC_CMD) ok = 1'b0;
    return ok;
  endfunction
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_stb = 1'b0;
    st_nxt.busy = (st_r.state != ST_IDLE);
    if (bus_stop || bus_start) begin
      // abandon partial byte, release, rematch
      st_nxt.state = bus_start ? ST_ADDR : ST_IDLE;
      st_nxt.bitcnt = '0;
      st_nxt.pend = 1'b0;
      st_nxt.sda_oe_n = 1'b1;
      st_nxt.sda_o = 1'b1;
    end else begin
      case (st_r.state)
        ST_IDLE: begin
          st_nxt.sda_oe_n = 1'b1;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda_s}; // msb first
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
          end
          if (scl_fall && st_r.bitcnt == 4'(i2cra_pkg::BITS_PER_BYTE)) begin
            st_nxt.bitcnt = '0;
            st_nxt.state = ST_ACK;
            st_nxt.sda_oe_n = 1'b0; // ack drives low
            st_nxt.sda_o = 1'b0;
            if (st_r.state == ST_ADDR) begin
              if (st_r.shift[7:1] != my_addr) begin
                st_nxt.state = ST_IDLE; // no ack on mismatch
                st_nxt.sda_oe_n = 1'b1;
              end else if (st_r.shift[0]) begin
                st_nxt.after_ack = ST_RDATA; // read after restart
              end else begin
                st_nxt.after_ack = ST_PTR;
              end
            end else if (st_r.state == ST_PTR) begin
              st_nxt.ptr = st_r.shift; // explicit pointer
              st_nxt.autoinc = 1'b0;
              st_nxt.wrapped = 1'b0;
              st_nxt.after_ack = ST_WDATA;
            end else begin
              // stored only once the ack completes
              st_nxt.pend = wr_allowed(st_r.ptr, st_r.autoinc) & ~st_r.wrapped;
              // a long burst must not wrap back into the window
              st_nxt.wrapped = st_r.wrapped | (&st_r.ptr);
              st_nxt.pend_loc = st_r.ptr;
              st_nxt.pend_data = st_r.shift;
              st_nxt.ptr = st_r.ptr + 8'h01; // advance after lsb
              st_nxt.autoinc = 1'b1;
              st_nxt.after_ack = ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_nxt.state = st_r.after_ack;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.sda_o = 1'b1;
            if (st_r.pend) begin
              st_nxt.wr_stb = 1'b1; // acknowledged full byte
              st_nxt.wr_loc = st_r.pend_loc;
              st_nxt.wr_data = st_r.pend_data;
              st_nxt.pend = 1'b0;
            end
            if (st_r.after_ack == ST_RDATA) begin
              st_nxt.shift = rd_byte; // load from pointer
              st_nxt.sda_oe_n = rd_byte[7]; // drive low bits only
              st_nxt.sda_o = rd_byte[7];
              st_nxt.bitcnt = '0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
            if (st_r.bitcnt == 4'(i2cra_pkg::BITS_PER_BYTE - 1)) begin
              st_nxt.state = ST_MACK;
              st_nxt.sda_oe_n = 1'b1; // release for master ack
              st_nxt.sda_o = 1'b1;
              // flag is sticky so every later byte reads ffh
              st_nxt.ptr = st_r.ptr + 8'h01; // advance after lsb
              st_nxt.wrapped = st_r.wrapped | (&st_r.ptr);
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b1};
              st_nxt.sda_oe_n = st_r.shift[6];
              st_nxt.sda_o = st_r.shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            st_nxt.shift[0] = sda_s; // master answer sampled
          end
          if (scl_fall) begin
            st_nxt.bitcnt = '0;
            if (st_r.shift[0]) begin
              st_nxt.state = ST_IDLE; // nack: keep released
            end else begin
              st_nxt.state = ST_RDATA;
              st_nxt.shift = rd_byte; // next byte at once
              st_nxt.sda_oe_n = rd_byte[7];
              st_nxt.sda_o = rd_byte[7];
            end
          end
        end
        default: st_nxt.state = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.after_ack <= ST_IDLE;
      st_r.sda_oe_n <= 1'b1;
      st_r.sda_o <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  // shadow memory; no nonvolatile path exists here
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < i2cra_pkg::MEM_DEPTH; i++) begin
        mem_r[i] <= i2cra_pkg::MEM_RST;
      end
      mem_r[i2cra_pkg::LOC_ADDR_CFG] <= {i2cra_pkg::ADDR_USER_RST, 4'h0};
    end else if (st_r.wr_stb) begin
      mem_r[st_r.wr_loc] <= st_r.wr_data;
    end
  end
  assign bus.sda_t_out = st_r.sda_o;
  assign bus.sda_t_oe_n = st_r.sda_oe_n;
  assign wr_loc_out = st_r.wr_loc;
  assign wr_data_out = st_r.wr_data;
  assign wr_stb_out = st_r.wr_stb;
  assign busy_out = st_r.busy;
endmodule // i2cra_target
`default_nettype wire

// >>> hw/i2cra_master.sv
// two-wire master: write bursts and pointer-set plus restart reads
// assumes one request at a time; scl made here by a divider
`timescale 1ns/10ps
`default_nettype none
module i2cra_master (
  input wire logic clk_in,
  input wire logic arst_n_in,
  i2cra_if.master bus,
  input wire logic req_in,
  input wire logic req_rd_in,
  input wire logic [6:0] req_addr_in,
  input wire logic [7:0] req_ptr_in,
  input wire logic [3:0] req_len_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_take_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic nak_out
);
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BIT, M_STOP, M_RSTART
  } i2cra_mstate_t;
  typedef struct packed {
    i2cra_mstate_t state;
    logic [15:0] div;
    logic [1:0] ph; // quarter phase inside a bit
    logic [3:0] bitn; // 0..7 data, 8 ack
    logic [1:0] stage; // 0 addr,1 ptr,2 data,3 read addr
    logic [7:0] shift;
    logic [3:0] left;
    logic rd_mode;
    logic scl;
    logic sda;
    logic take;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic nak;
    logic [1:0] sda_sync; // line seen through two flops
  } i2cra_mst_t;
  i2cra_mst_t st_r, st_nxt;
  logic sda_s;
  logic tick, last_bit;
  // only the second stage is read, the first may be metastable
  assign sda_s = st_r.sda_sync[1];
  assign tick = (st_r.div == 16'(i2cra_pkg::SCL_HALF_CYC / 2 - 1));
  assign last_bit = (st_r.bitn == 4'(i2cra_pkg::BITS_PER_BYTE));
  always_comb begin
    st_nxt = st_r;
    st_nxt.take = 1'b0;
    st_nxt.rd_valid = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.sda_sync = {st_r.sda_sync[0], bus.sda};
    st_nxt.div = tick ? 16'h0000 : st_r.div + 16'h0001;
    if (st_r.state == M_IDLE) st_nxt.div = '0;
    case (st_r.state)
      M_IDLE: begin
        st_nxt.scl = 1'b1;
        st_nxt.sda = 1'b1;
        if (req_in) begin
          st_nxt.state = M_START;
          st_nxt.rd_mode = req_rd_in;
          st_nxt.left = req_len_in;
          st_nxt.nak = 1'b0;
          st_nxt.ph = '0;
        end
      end
      M_START, M_RSTART: begin
        // restart: raise sda, raise scl, then start
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          case (st_r.ph)
            2'h0: st_nxt.sda = 1'b1;
            2'h1: st_nxt.scl = 1'b1;
            2'h2: st_nxt.sda = 1'b0; // start
            default: begin
              st_nxt.scl = 1'b0;
              st_nxt.state = M_BIT;
              st_nxt.bitn = '0;
              st_nxt.stage = (st_r.state == M_RSTART) ? 2'h3 : 2'h0;
              st_nxt.shift = {req_addr_in, st_r.state == M_RSTART};
            end
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          case (st_r.ph)
            2'h0: begin
              // set sda while scl low
              if (last_bit) st_nxt.sda = (st_r.stage == 2'h2 && st_r.rd_mode) ?
                (st_r.left == 4'h1) : 1'b1; // ack or nack of read
              else st_nxt.sda = (st_r.stage == 2'h2 && st_r.rd_mode) ? 1'b1 : st_r.shift[7];
            end
            2'h1: st_nxt.scl = 1'b1;
            2'h2: begin
              if (!last_bit) st_nxt.rd_data = {st_r.rd_data[6:0], sda_s};
              else if (!(st_r.stage == 2'h2 && st_r.rd_mode)) st_nxt.nak = sda_s;
            end
            default: begin
              st_nxt.scl = 1'b0;
              st_nxt.shift = {st_r.shift[6:0], 1'b1};
              st_nxt.bitn = st_r.bitn + 4'h1;
              if (last_bit) begin
                st_nxt.bitn = '0;
                st_nxt.shift = wr_data_in;
                if (st_r.nak) begin
                  st_nxt.state = M_STOP;
                end else if (st_r.stage == 2'h0) begin
                  st_nxt.stage = 2'h1;
                  st_nxt.shift = req_ptr_in;
                end else if (st_r.stage == 2'h1) begin
                  st_nxt.stage = 2'h2;
                  if (st_r.rd_mode) st_nxt.state = M_RSTART;
                  else st_nxt.take = 1'b1;
                  if (!st_r.rd_mode && st_r.left == 4'h0) st_nxt.state = M_STOP;
                end else begin
                  if (st_r.stage == 2'h3) st_nxt.stage = 2'h2;
                  else st_nxt.left = st_r.left - 4'h1;
                  if (st_r.stage == 2'h2 && st_r.rd_mode) st_nxt.rd_valid = 1'b1;
                  if (st_r.stage == 2'h2 && st_r.left == 4'h1) begin
                    st_nxt.state = M_STOP; // end after last ack
                  end else if (!st_r.rd_mode) begin
                    st_nxt.take = 1'b1;
                  end
                end
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          st_nxt.ph = st_r.ph + 2'h1;
          case (st_r.ph)
            2'h0: st_nxt.sda = 1'b0;
            2'h1: st_nxt.scl = 1'b1;
            2'h2: st_nxt.sda = 1'b1; // stop
            default: begin
              st_nxt.state = M_IDLE;
              st_nxt.done = 1'b1;
            end
          endcase
        end
      end
      default: st_nxt.state = M_IDLE;
    endcase
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
      st_r.state <= M_IDLE;
      st_r.scl <= 1'b1;
      st_r.sda <= 1'b1;
      st_r.sda_sync <= 2'h3; // idle line reads high
    end else begin
      st_r <= st_nxt;
    end
  end
  // master drives sda low only; it releases sda for target acks and read data bits
  assign bus.scl_m_out = 1'b0;
  assign bus.scl_m_oe_n = st_r.scl;
  assign bus.sda_m_out = 1'b0;
  assign bus.sda_m_oe_n = st_r.sda;
  assign wr_take_out = st_r.take;
  assign rd_data_out = st_r.rd_data;
  assign rd_valid_out = st_r.rd_valid;
  assign done_out = st_r.done;
  assign nak_out = st_r.nak;
endmodule // i2cra_master
`default_nettype wire

// >>> tb/i2cra_monitor.sv
// concurrent checks on the two-wire carrier between target and master
// assumes it sees the resolved lines, every end's drives and the local clock
`timescale 1ns/10ps
`default_nettype none
module i2cra_monitor (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_out,
  input wire logic scl_m_oe_n,
  input wire logic sda_m_out,
  input wire logic sda_m_oe_n,
  input wire logic sda_t_out,
  input wire logic sda_t_oe_n
);
  logic scl_d, sda_d, first_r, rw_r;
  logic st, sp, rise, fall;
  logic [3:0] fcnt;
  logic [7:0] sh, nak_cnt;
  logic [11:0] drv_cnt;
  // bus conditions seen straight off the lines, ahead of the ends and their two-stage synchronisers
  assign st = scl & scl_d & sda_d & ~sda;
  assign sp = scl & scl_d & ~sda_d & sda;
  assign rise = scl & ~scl_d;
  assign fall = ~scl & scl_d;
  // frame position: scl falls since start, address byte flag, direction
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      fcnt <= 4'h0;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      sh <= 8'h00;
      nak_cnt <= 8'h00;
      drv_cnt <= 12'h000;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      drv_cnt <= sda_t_oe_n ? 12'h000 : drv_cnt + 12'h001;
      if (rise) sh <= {sh[6:0], sda};
      if (rise && first_r && fcnt == 4'h7) rw_r <= sda;
      if (st || sp) begin
        // the fall that closes a start is no bit, so count from minus one
        fcnt <= st ? 4'hf : 4'h0;
        first_r <= st;
        nak_cnt <= 8'h00;
      end else begin
        if (fall) fcnt <= (fcnt == 4'h8) ? 4'h0 : fcnt + 4'h1;
        if (fall && fcnt == 4'h8) first_r <= 1'b0;
        // saturating count so a late restart of the target still shows
        if (rise && fcnt == 4'h8 && rw_r && !first_r && sda) nak_cnt <= 8'h01;
        else if (nak_cnt != 8'h00 && nak_cnt != 8'hff) nak_cnt <= nak_cnt + 8'h01;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_target_open_drain: assert property (!sda_t_oe_n |-> !sda_t_out)
    else $error("target drives sda high");
  chk_master_ack_free: assert property ((first_r && fcnt == 4'h8 && scl) |-> (sda_m_oe_n || sda_m_out))
    else $error("master pulls sda in the address acknowledge slot");
  chk_target_steady_high: assert property ((scl && scl_d) |-> $stable(sda_t_oe_n))
    else $error("target sda drive changes while scl high");
  chk_addr_no_drive: assert property ((first_r && fcnt < 4'h8) |-> sda_t_oe_n)
    else $error("target drives during address byte");
  chk_foreign_addr_nak: assert property ((first_r && fcnt == 4'h8 && rise
    && sh[7:5] != 3'h3) |-> sda)
    else $error("target acknowledges foreign address");
  chk_ack_then_release: assert property ((fall && fcnt == 4'h8 && !rw_r)
    |-> ##[1:8] sda_t_oe_n)
    else $error("target holds sda after write acknowledge");
  chk_write_ack_slot: assert property (($fell(sda_t_oe_n) && !rw_r) |-> fcnt == 4'h8)
    else $error("target drives outside the acknowledge slot");
  chk_nak_stays_off: assert property ((nak_cnt > 8'h8c) |-> sda_t_oe_n)
    else $error("target sends data after master nak");
  chk_drive_bounded: assert property (drv_cnt < 12'h960)
    else $error("target drives sda longer than nine bits");
  chk_stop_released: assert property (sp |-> sda_t_oe_n [*8])
    else $error("target drives right after stop");
endmodule // i2cra_monitor
`default_nettype wire

// >>> tb/tb_i2c_register_access_slave.sv
// bench: master and target joined on one carrier, checked against a model
// assumes the package constants, a 100 MHz clock and the master's divider
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t got %0h want %0h", $time, a, b); end end
module tb_i2c_register_access_slave;
  logic clk_in, arst_n_in, req, req_rd, take, rdv, done, nak, stb, busy, busy_seen;
  logic [6:0] req_addr;
  logic [7:0] req_ptr, wdat, rdat, wloc, wdata;
  logic [3:0] req_len;
  logic [31:0] seed;
  int mismatches, n_tests, widx;
  logic [7:0] mem [256];
  logic [7:0] wq[$], sq[$], eq[$], rq[$];
  int xq[$];
  i2cra_if bus ();
  i2cra_target i_i2cra_target (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus(bus.target),
    .wr_loc_out(wloc), .wr_data_out(wdata), .wr_stb_out(stb), .busy_out(busy));
  i2cra_master i_i2cra_master (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus(bus.master),
    .req_in(req), .req_rd_in(req_rd), .req_addr_in(req_addr), .req_ptr_in(req_ptr),
    .req_len_in(req_len), .wr_data_in(wdat), .wr_take_out(take), .rd_data_out(rdat),
    .rd_valid_out(rdv), .done_out(done), .nak_out(nak));
  i2cra_monitor i_i2cra_monitor (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl(bus.scl),
    .sda(bus.sda), .scl_m_out(bus.scl_m_out), .scl_m_oe_n(bus.scl_m_oe_n),
    .sda_m_out(bus.sda_m_out), .sda_m_oe_n(bus.sda_m_oe_n), .sda_t_out(bus.sda_t_out),
    .sda_t_oe_n(bus.sda_t_oe_n));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // target address as the model's address location now sets it
  function automatic logic [6:0] cur();
    return {i2cra_pkg::ADDR_FIXED_HI, mem[i2cra_pkg::LOC_ADDR_CFG][7:4]};
  endfunction
  // collect stores and read bytes; next write byte after each take
  always @(negedge clk_in) begin
    if (stb === 1'b1) begin
      sq.push_back(wloc);
      sq.push_back(wdata);
    end
    if (rdv === 1'b1) rq.push_back(rdat);
    if (busy === 1'b1) busy_seen = 1'b1;
    if (take === 1'b1) begin
      widx++;
      if (widx < wq.size()) wdat <= wq[widx];
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one transaction: model first, then drive the master and compare
  task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] p, input int len);
    int loc;
    logic ack;
    ack = (a === cur());
    wq.delete();
    eq.delete();
    xq.delete();
    sq.delete();
    rq.delete();
    busy_seen = 1'b0;
    for (int n = 0; n < len; n++) begin
      seed = lfsr(seed);
      wq.push_back(seed[7:0]);
      loc = p + n;
      if (rd && ack) begin
        // upper locations hold reserved bytes, so only known ones count
        xq.push_back(loc >= i2cra_pkg::MEM_DEPTH ? int'(i2cra_pkg::READ_PAST_END) :
          (loc < i2cra_pkg::MEM_DEPTH / 2 ? int'(mem[loc]) : -1));
      end else if (!rd && ack && loc >= int'(i2cra_pkg::LOC_RO_LIMIT) &&
        (n == 0 || loc <= int'(i2cra_pkg::LOC_WRITE_LAST))) begin
        mem[loc] = seed[7:0];
        eq.push_back(8'(loc));
        eq.push_back(seed[7:0]);
      end
    end
    @(negedge clk_in);
    widx = 0;
    wdat = (wq.size() > 0) ? wq[0] : 8'h00;
    req_rd = rd;
    req_addr = a;
    req_ptr = p;
    req_len = len[3:0];
    req = 1'b1;
    @(negedge clk_in);
    req = 1'b0;
    for (int t = 0; t < 40000 && done !== 1'b1; t++) @(negedge clk_in);
    `CHK(done, 1'b1)
    repeat (4) @(negedge clk_in);
    `CHK(nak, ~ack)
    `CHK(busy, 1'b0)
    `CHK(busy_seen, 1'b1)
    `CHK(sq.size(), eq.size())
    for (int i = 0; i < eq.size() && i < sq.size(); i++) `CHK(sq[i], eq[i])
    `CHK(rq.size(), xq.size())
    for (int i = 0; i < xq.size() && i < rq.size(); i++)
      if (xq[i] >= 0) `CHK(rq[i], 8'(xq[i]))
  endtask
  // a hang ends the run through the same closing task
  initial begin
    #1100000;
    mismatches++;
    close_out();
  end
  initial begin
    arst_n_in = 1'b0;
    req = 1'b0;
    req_rd = 1'b0;
    req_addr = 7'h00;
    req_ptr = 8'h00;
    req_len = 4'h0;
    wdat = 8'h00;
    seed = 32'h81820f33;
    mismatches = 0;
    n_tests = 0;
    foreach (mem[i]) mem[i] = i2cra_pkg::MEM_RST;
    mem[i2cra_pkg::LOC_ADDR_CFG] = {i2cra_pkg::ADDR_USER_RST, 4'h0};
    repeat (16) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    run(1'b0, 7'h5a, 8'h40, 1);
    run(1'b0, cur(), 8'h4e, 4);
    run(1'b0, cur(), 8'h1f, 2);
    run(1'b1, cur(), 8'h4d, 3);
    run(1'b1, cur(), 8'hfe, 3);
    run(1'b0, cur(), 8'hfd, 2);
    run(1'b0, cur(), i2cra_pkg::LOC_ADDR_CFG, 1);
    run(1'b0, 7'h36, i2cra_pkg::LOC_ADDR_CFG, 0);
    run(1'b1, cur(), i2cra_pkg::LOC_ADDR_CFG, 1);
    close_out();
  end
endmodule // tb_i2c_register_access_slave
`default_nettype wire
